// >>> core/cise_pkg.sv
// Summary of operation
// RULE1: Load secondary register copies accumulator to register 0..15; one cycle, no flags.
// RULE2: Enter halt clears watchdog counter and watchdog prescaler to zero.
// RULE3: Enter halt sets timeout flag, clears powerdown flag; nothing else changes.
// RULE4: After enter halt the core stops executing; instruction takes one cycle.
// RULE5: Register subtract computes file register minus accumulator, address 0..63, one cycle.
// RULE6: Destination bit 0 writes accumulator, 1 writes back the file register.
// RULE7: Both subtracts update zero, digit carry, carry; carry clear means borrow.
// RULE8: Immediate subtract computes immediate minus accumulator into accumulator; one cycle.
// RULE9: Table read addresses {pointer_high[2:0], accumulator}; two cycles, no flags.
// RULE10: Table read loads word bits 7:0 into the accumulator.
// RULE11: Table read loads word bits 13:8 into table_data_high bits 5:0.
// RULE12: Leaving halt is external; block only raises a halt request.
`default_nettype none
package cise_pkg;
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int SREG_ADDR_W = 4;
  localparam int FREG_ADDR_W = 6;
  localparam int PROG_ADDR_W = 11;
  localparam int PROG_DATA_W = 14;
  localparam int PTR_HI_W = 3;
  localparam int TDH_W = 6;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [5:0] TDH_RST = 6'h00;

  typedef enum logic [2:0] {
    CISE_OP_NONE = 3'h0,
    CISE_OP_LDS = 3'h1,
    CISE_OP_HALT = 3'h2,
    CISE_OP_SUBR = 3'h3,
    CISE_OP_SUBI = 3'h4,
    CISE_OP_TBL = 3'h5
  } cise_op_t;

  // Gray coded along run -> table -> run and run -> halt -> run
  typedef enum logic [1:0] {
    CISE_ST_RUN = 2'b00,
    CISE_ST_TBL = 2'b01,
    CISE_ST_HALT = 2'b10
  } cise_state_t;
endpackage : cise_pkg
`default_nettype wire

// >>> core/cise_exec.sv
`timescale 1ns/100ps
`default_nettype none
module cise_exec (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_valid,
  input wire cise_pkg::cise_op_t i_op,
  input wire logic [cise_pkg::SREG_ADDR_W-1:0] i_sreg_addr,
  input wire logic [cise_pkg::FREG_ADDR_W-1:0] i_freg_addr,
  input wire logic i_dest,
  input wire logic [cise_pkg::DATA_W-1:0] i_imm,
  input wire logic [cise_pkg::DATA_W-1:0] i_freg_rdata,
  input wire logic [cise_pkg::PTR_HI_W-1:0] i_ptr_high,
  input wire logic [cise_pkg::PROG_DATA_W-1:0] i_prog_rdata,
  input wire logic i_wake,
  output logic o_ready,
  output logic [cise_pkg::FREG_ADDR_W-1:0] o_freg_raddr,
  output logic [cise_pkg::DATA_W-1:0] o_acc,
  output logic o_sreg_we,
  output logic [cise_pkg::SREG_ADDR_W-1:0] o_sreg_addr,
  output logic [cise_pkg::DATA_W-1:0] o_sreg_wdata,
  output logic o_freg_we,
  output logic [cise_pkg::FREG_ADDR_W-1:0] o_freg_waddr,
  output logic [cise_pkg::DATA_W-1:0] o_freg_wdata,
  output logic o_zero,
  output logic o_digit_carry,
  output logic o_carry,
  output logic o_timeout_flag,
  output logic o_powerdown_flag,
  output logic o_wdt_clear,
  output logic o_halt_req,
  output logic [cise_pkg::PROG_ADDR_W-1:0] o_prog_addr,
  output logic [cise_pkg::TDH_W-1:0] o_table_data_high
);
  // ************************************************************
  // Decode and arithmetic
  // ************************************************************
  cise_pkg::cise_state_t state_q;
  logic acc_we;
  logic [cise_pkg::DATA_W-1:0] acc_q;
  logic [cise_pkg::DATA_W-1:0] minuend;
  logic [cise_pkg::DATA_W:0] diff;
  logic [cise_pkg::NIB_W:0] ldiff;
  logic go;
  logic is_sub;

  // Minuend minus accumulator as minuend + ~acc + 1
  function automatic logic [cise_pkg::DATA_W:0] sub9(
    input logic [cise_pkg::DATA_W-1:0] a,
    input logic [cise_pkg::DATA_W-1:0] b
  );
    sub9 = {1'b0, a} + {1'b0, ~b} + 9'h001;
  endfunction : sub9

  assign o_ready = (state_q == cise_pkg::CISE_ST_RUN);
  assign go = i_ce && i_valid && o_ready;
  assign is_sub = (i_op == cise_pkg::CISE_OP_SUBR) ||
    (i_op == cise_pkg::CISE_OP_SUBI);
  assign o_freg_raddr = i_freg_addr;
  assign minuend = (i_op == cise_pkg::CISE_OP_SUBI) ? i_imm : i_freg_rdata;
  assign diff = sub9(minuend, acc_q); // RULE5 RULE8
  assign ldiff = {1'b0, minuend[cise_pkg::NIB_W-1:0]} +
    {1'b0, ~acc_q[cise_pkg::NIB_W-1:0]} + 5'h01;
  assign o_acc = acc_q;
  assign o_prog_addr = {i_ptr_high, acc_q}; // RULE9

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= cise_pkg::CISE_ST_RUN;
    end else if (i_ce) begin
      case (state_q)
        cise_pkg::CISE_ST_RUN: begin
          if (go && i_op == cise_pkg::CISE_OP_HALT) begin
            state_q <= cise_pkg::CISE_ST_HALT; // RULE4
          end else if (go && i_op == cise_pkg::CISE_OP_TBL) begin
            state_q <= cise_pkg::CISE_ST_TBL; // RULE9
          end
        end
        cise_pkg::CISE_ST_TBL: state_q <= cise_pkg::CISE_ST_RUN;
        cise_pkg::CISE_ST_HALT: begin
          // Only an outside wake-up source or a reset releases the core
          if (i_wake) begin
            state_q <= cise_pkg::CISE_ST_RUN; // RULE12
          end
        end
        default: state_q <= cise_pkg::CISE_ST_RUN;
      endcase
    end
  end

  assign o_halt_req = (state_q == cise_pkg::CISE_ST_HALT); // RULE12

  // ************************************************************
  // Accumulator and table data
  // ************************************************************
  assign acc_we = (go && i_op == cise_pkg::CISE_OP_SUBR && !i_dest) ||
    (go && i_op == cise_pkg::CISE_OP_SUBI);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_q <= cise_pkg::ACC_RST;
    end else if (i_ce) begin
      if (acc_we) begin
        acc_q <= diff[cise_pkg::DATA_W-1:0]; // RULE6 RULE8
      end else if (state_q == cise_pkg::CISE_ST_TBL) begin
        acc_q <= i_prog_rdata[cise_pkg::DATA_W-1:0]; // RULE10
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_table_data_high <= cise_pkg::TDH_RST;
    end else if (i_ce && state_q == cise_pkg::CISE_ST_TBL) begin
      o_table_data_high <=
        i_prog_rdata[cise_pkg::PROG_DATA_W-1:cise_pkg::DATA_W]; // RULE11
    end
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sreg_we <= 1'b0;
      o_sreg_addr <= '0;
      o_sreg_wdata <= '0;
    end else if (i_ce) begin
      o_sreg_we <= go && i_op == cise_pkg::CISE_OP_LDS; // RULE1
      o_sreg_addr <= i_sreg_addr;
      o_sreg_wdata <= acc_q; // RULE1
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_freg_we <= 1'b0;
      o_freg_waddr <= '0;
      o_freg_wdata <= '0;
    end else if (i_ce) begin
      o_freg_we <= go && i_op == cise_pkg::CISE_OP_SUBR && i_dest; // RULE6
      o_freg_waddr <= i_freg_addr;
      o_freg_wdata <= diff[cise_pkg::DATA_W-1:0];
    end
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_zero <= 1'b0;
      o_digit_carry <= 1'b0;
      o_carry <= 1'b0;
    end else if (i_ce && go && is_sub) begin
      o_zero <= (diff[cise_pkg::DATA_W-1:0] == 8'h00); // RULE7
      o_digit_carry <= ldiff[cise_pkg::NIB_W]; // RULE7
      o_carry <= diff[cise_pkg::DATA_W]; // RULE7
    end
  end

  // Reset loads the two halt flags here: timeout flag 0, powerdown flag 1
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_timeout_flag <= 1'b0;
      o_powerdown_flag <= 1'b1;
      o_wdt_clear <= 1'b0;
    end else if (i_ce) begin
      o_wdt_clear <= go && i_op == cise_pkg::CISE_OP_HALT; // RULE2
      if (go && i_op == cise_pkg::CISE_OP_HALT) begin
        o_timeout_flag <= 1'b1; // RULE3
        o_powerdown_flag <= 1'b0; // RULE3
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_lds;
    @(posedge i_mclk) disable iff (!i_resetn)
    (go && i_op == cise_pkg::CISE_OP_LDS) |=>
      (o_sreg_we && o_sreg_wdata == $past(acc_q) && o_carry == $past(o_carry));
  endproperty
  a_lds: assert property (p_lds) else $error("sreg load bad"); // RULE1

  property p_wdt;
    @(posedge i_mclk) disable iff (!i_resetn)
    (go && i_op == cise_pkg::CISE_OP_HALT) |=> o_wdt_clear;
  endproperty
  a_wdt: assert property (p_wdt) else $error("no wdt clear"); // RULE2

  property p_flags;
    @(posedge i_mclk) disable iff (!i_resetn)
    (go && i_op == cise_pkg::CISE_OP_HALT) |=>
      (o_timeout_flag && !o_powerdown_flag && $stable(o_zero));
  endproperty
  a_flags: assert property (p_flags) else $error("halt flags bad"); // RULE3

  property p_halt;
    @(posedge i_mclk) disable iff (!i_resetn)
    (go && i_op == cise_pkg::CISE_OP_HALT) |=> (o_halt_req && !o_ready);
  endproperty
  a_halt: assert property (p_halt) else $error("halt not entered"); // RULE4

  property p_subr;
    @(posedge i_mclk) disable iff (!i_resetn)
    (go && i_op == cise_pkg::CISE_OP_SUBR && i_dest) |=>
      (o_freg_we && o_freg_wdata == $past(i_freg_rdata) - $past(acc_q));
  endproperty
  a_subr: assert property (p_subr) else $error("subr result bad"); // RULE6

  property p_carry;
    @(posedge i_mclk) disable iff (!i_resetn)
    (go && is_sub) |=> (o_carry == ($past(minuend) >= $past(acc_q)));
  endproperty
  a_carry: assert property (p_carry) else $error("carry bad"); // RULE7

  property p_subi;
    @(posedge i_mclk) disable iff (!i_resetn)
    (go && i_op == cise_pkg::CISE_OP_SUBI) |=>
      (acc_q == $past(i_imm) - $past(acc_q));
  endproperty
  a_subi: assert property (p_subi) else $error("subi result bad"); // RULE8

  sequence s_tbl_start;
    go && i_op == cise_pkg::CISE_OP_TBL;
  endsequence
  sequence s_tbl_busy;
    !o_ready ##1 o_ready;
  endsequence
  property p_tbl;
    @(posedge i_mclk) disable iff (!i_resetn || !i_ce)
    s_tbl_start |=> s_tbl_busy;
  endproperty
  a_tbl: assert property (p_tbl) else $error("table timing bad"); // RULE9

  property p_tbl_data;
    @(posedge i_mclk) disable iff (!i_resetn)
    (i_ce && state_q == cise_pkg::CISE_ST_TBL) |=>
      (acc_q == $past(i_prog_rdata[7:0]) &&
       o_table_data_high == $past(i_prog_rdata[13:8]));
  endproperty
  a_tbl_data: assert property (p_tbl_data) // RULE10 RULE11
    else $error("table data bad");

  // ************************************************************
  // Further checks
  // ************************************************************
  property p_subr_acc;
    @(posedge i_mclk) disable iff (!i_resetn)
    (go && i_op == cise_pkg::CISE_OP_SUBR && !i_dest) |=>
      (!o_freg_we && acc_q == $past(i_freg_rdata) - $past(acc_q));
  endproperty
  a_subr_acc: assert property (p_subr_acc) else $error("acc bad"); // RULE6

  property p_zero;
    @(posedge i_mclk) disable iff (!i_resetn)
    (go && is_sub) |=> (o_zero == ($past(minuend) == $past(acc_q)));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag bad"); // RULE7

  property p_digit;
    @(posedge i_mclk) disable iff (!i_resetn)
    (go && is_sub) |=>
      (o_digit_carry == ($past(minuend[cise_pkg::NIB_W-1:0]) >=
       $past(acc_q[cise_pkg::NIB_W-1:0])));
  endproperty
  a_digit: assert property (p_digit) else $error("digit carry bad"); // RULE7

  property p_subi_dest;
    @(posedge i_mclk) disable iff (!i_resetn)
    (go && i_op == cise_pkg::CISE_OP_SUBI) |=> (!o_freg_we && !o_sreg_we);
  endproperty
  a_subi_dest: assert property (p_subi_dest) // RULE8
    else $error("subi dest bad");

  sequence s_flags_held;
    $stable({o_zero, o_digit_carry, o_carry});
  endsequence
  property p_tbl_flags;
    @(posedge i_mclk) disable iff (!i_resetn || !i_ce)
    s_tbl_start |=> s_flags_held ##1 s_flags_held;
  endproperty
  a_tbl_flags: assert property (p_tbl_flags) // RULE9
    else $error("table changed flags");

  property p_halt_stay;
    @(posedge i_mclk) disable iff (!i_resetn)
    (o_halt_req && !i_wake) |=> (o_halt_req && $stable(acc_q));
  endproperty
  a_halt_stay: assert property (p_halt_stay) // RULE4
    else $error("halt not held");

  property p_wdt_pulse;
    @(posedge i_mclk) disable iff (!i_resetn)
    (o_wdt_clear && i_ce) |=> !o_wdt_clear;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) // RULE2
    else $error("wdt clear too long");

  // Wake is level sensitive, so one sampled high edge is enough to leave
  property p_wake;
    @(posedge i_mclk) disable iff (!i_resetn)
    (o_halt_req && i_ce && i_wake) |=> (o_ready && !o_halt_req);
  endproperty
  a_wake: assert property (p_wake) else $error("wake ignored"); // RULE12
endmodule : cise_exec
`default_nettype wire

// >>> dv/cise_exec_bench.sv
`timescale 1ns/100ps
`default_nettype none
module cise_exec_bench;
  // ****************************************
  // Stimulus and far-side memories
  // ****************************************
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ce = 1'b1;
  logic i_valid = 1'b0;
  logic i_dest = 1'b0;
  logic i_wake = 1'b0;
  cise_pkg::cise_op_t i_op = cise_pkg::CISE_OP_NONE;
  logic [3:0] i_sreg_addr = 4'h0;
  logic [5:0] i_freg_addr = 6'h00;
  logic [7:0] i_imm = 8'h00;
  logic [2:0] i_ptr_high = 3'h2;
  logic [7:0] i_freg_rdata;
  logic [13:0] i_prog_rdata;
  logic o_ready, o_sreg_we, o_freg_we, o_zero, o_digit_carry, o_carry;
  logic o_timeout_flag, o_powerdown_flag, o_wdt_clear, o_halt_req;
  logic [5:0] o_freg_raddr, o_freg_waddr, o_table_data_high;
  logic [7:0] o_acc, o_sreg_wdata, o_freg_wdata, ea;
  logic [3:0] o_sreg_addr;
  logic [10:0] o_prog_addr, ta;
  logic [2:0] f;
  int num_errors = 0;
  int checked = 0;
  // Address-dependent contents, so a wrong address gives wrong data
  assign i_freg_rdata = 8'h40 + {2'h0, o_freg_raddr};
  assign i_prog_rdata = {o_prog_addr[10:5] ^ 6'h15, o_prog_addr[7:0] ^ 8'hC3};
  always #12.5 i_mclk = ~i_mclk;
  cise_exec u_cise_exec (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_valid(i_valid),
    .i_op(i_op),
    .i_sreg_addr(i_sreg_addr),
    .i_freg_addr(i_freg_addr),
    .i_dest(i_dest),
    .i_imm(i_imm),
    .i_freg_rdata(i_freg_rdata),
    .i_ptr_high(i_ptr_high),
    .i_prog_rdata(i_prog_rdata),
    .i_wake(i_wake),
    .o_ready(o_ready),
    .o_freg_raddr(o_freg_raddr),
    .o_acc(o_acc),
    .o_sreg_we(o_sreg_we),
    .o_sreg_addr(o_sreg_addr),
    .o_sreg_wdata(o_sreg_wdata),
    .o_freg_we(o_freg_we),
    .o_freg_waddr(o_freg_waddr),
    .o_freg_wdata(o_freg_wdata),
    .o_zero(o_zero),
    .o_digit_carry(o_digit_carry),
    .o_carry(o_carry),
    .o_timeout_flag(o_timeout_flag),
    .o_powerdown_flag(o_powerdown_flag),
    .o_wdt_clear(o_wdt_clear),
    .o_halt_req(o_halt_req),
    .o_prog_addr(o_prog_addr),
    .o_table_data_high(o_table_data_high)
  );
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic go(input cise_pkg::cise_op_t op, input logic [7:0] v,
                    input logic [5:0] a, input logic d);
    @(posedge i_mclk);
    i_valid <= 1'b1;
    i_op <= op;
    i_imm <= v;
    i_freg_addr <= a;
    i_sreg_addr <= a[3:0];
    i_dest <= d;
    @(posedge i_mclk);
    i_valid <= 1'b0;
    #1;
  endtask : go
  task automatic sub(input cise_pkg::cise_op_t op, input logic [7:0] m,
                     input logic [5:0] a, input logic d);
    logic [7:0] r;
    r = m - ea;
    go(op, m, a, d);
    chk({o_zero, o_carry}, {r == 8'h00, m >= ea});
    chk(o_digit_carry, m[3:0] >= ea[3:0]);
    chk(o_freg_raddr, a);
    chk(o_freg_we, d && op == cise_pkg::CISE_OP_SUBR);
    if (d && op == cise_pkg::CISE_OP_SUBR) begin
      chk({o_freg_waddr, o_freg_wdata}, {a, r});
    end else begin
      ea = r;
    end
    chk(o_acc, ea);
  endtask : sub
  task automatic report_and_stop;
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    ea = 8'h00;
    repeat (3) @(posedge i_mclk);
    i_resetn <= 1'b1;
    #1;
    chk({o_acc, o_timeout_flag, o_powerdown_flag}, {8'h00, 2'b01});
    chk({o_ready, o_halt_req, o_wdt_clear, o_table_data_high}, 9'h100);
    sub(cise_pkg::CISE_OP_SUBI, 8'h05, 6'h00, 1'b0);
    sub(cise_pkg::CISE_OP_SUBI, 8'h04, 6'h00, 1'b0);
    sub(cise_pkg::CISE_OP_SUBI, 8'hFF, 6'h00, 1'b0);
    sub(cise_pkg::CISE_OP_SUBI, 8'h10, 6'h00, 1'b0);
    sub(cise_pkg::CISE_OP_SUBI, 8'h0F, 6'h00, 1'b0);
    sub(cise_pkg::CISE_OP_SUBR, 8'h7F, 6'h3F, 1'b1);
    sub(cise_pkg::CISE_OP_SUBR, 8'h40, 6'h00, 1'b0);
    sub(cise_pkg::CISE_OP_SUBR, 8'h41, 6'h01, 1'b0);
    sub(cise_pkg::CISE_OP_SUBI, 8'h34, 6'h00, 1'b0);
    sub(cise_pkg::CISE_OP_SUBI, 8'h56, 6'h3F, 1'b1);
    for (int k = 0; k < 16; k += 15) begin
      f = {o_zero, o_digit_carry, o_carry};
      go(cise_pkg::CISE_OP_LDS, 8'h00, 6'(k), 1'b0);
      chk({o_sreg_we, o_sreg_addr, o_sreg_wdata}, {1'b1, 4'(k), ea});
      chk({o_zero, o_digit_carry, o_carry, o_acc}, {f, ea});
    end
    ta = {3'h2, ea};
    go(cise_pkg::CISE_OP_TBL, 8'h00, 6'h00, 1'b0);
    chk({o_ready, o_prog_addr}, {1'b0, ta});
    @(posedge i_mclk);
    #1;
    chk(o_acc, ta[7:0] ^ 8'hC3);
    chk(o_table_data_high, ta[10:5] ^ 6'h15);
    chk({o_ready, o_zero, o_digit_carry, o_carry}, {1'b1, f});
    ea = ta[7:0] ^ 8'hC3;
    // Clock enable low must swallow an otherwise legal request
    @(posedge i_mclk);
    i_ce <= 1'b0;
    go(cise_pkg::CISE_OP_SUBI, 8'h99, 6'h00, 1'b0);
    chk({o_acc, o_ready, o_freg_we}, {ea, 2'b10});
    @(posedge i_mclk);
    i_ce <= 1'b1;
    go(cise_pkg::CISE_OP_HALT, 8'h00, 6'h00, 1'b0);
    chk({o_halt_req, o_wdt_clear, o_ready}, 3'b110);
    chk({o_timeout_flag, o_powerdown_flag}, 2'b10);
    chk({o_zero, o_digit_carry, o_carry}, f);
    go(cise_pkg::CISE_OP_SUBI, 8'h77, 6'h00, 1'b0);
    chk({o_acc, o_wdt_clear, o_halt_req}, {ea, 2'b01});
    @(posedge i_mclk);
    i_wake <= 1'b1;
    @(posedge i_mclk);
    i_wake <= 1'b0;
    @(posedge i_mclk);
    #1;
    chk({o_halt_req, o_ready}, 2'b01);
    sub(cise_pkg::CISE_OP_SUBI, 8'h10, 6'h00, 1'b0);
    // A reset in mid-run must release a halted core as well
    go(cise_pkg::CISE_OP_HALT, 8'h00, 6'h00, 1'b0);
    chk(o_halt_req, 1'b1);
    @(posedge i_mclk);
    i_resetn <= 1'b0;
    @(posedge i_mclk);
    i_resetn <= 1'b1;
    #1;
    chk({o_halt_req, o_ready}, 2'b01);
    chk({o_timeout_flag, o_powerdown_flag, o_acc}, {2'b01, 8'h00});
    report_and_stop;
  end
  // A hang shows up well beyond the fifty or so cycles the tests need
  initial begin
    #100000;
    num_errors++;
    report_and_stop;
  end
endmodule : cise_exec_bench
`default_nettype wire
